// [fifo_dev_end.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

// Storage buffer with valid/ready handshakes on both sides
module word_buffer #(
   parameter int WIDTH = `SLICE_W,
   parameter int DEPTH = `DEPTH
) (
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);

   // Buffer state: word store, pointers and fill count
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0] count;
   } buf_state_t;

   buf_state_t st_r; // Registered state
   buf_state_t st_nxt; // Next state
   logic push; // Word accepted on fill side
   logic pop; // Word taken on drain side

   // Handshake terms derived from the fill count
   assign in_ready = (st_r.count != (PW+1)'(DEPTH));
   assign out_valid = (st_r.count != '0);
   assign out_data = st_r.mem[st_r.rptr];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Next-state logic: write at the write pointer, advance on pop
   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.mem[st_r.wptr] = in_data;
         st_nxt.wptr = st_r.wptr + 1'b1;
      end
      if (pop) begin
         st_nxt.rptr = st_r.rptr + 1'b1;
      end
      case ({push, pop})
         2'b10: st_nxt.count = st_r.count + 1'b1;
         2'b01: st_nxt.count = st_r.count - 1'b1;
         default: st_nxt.count = st_r.count;
      endcase
   end

   // State register; both pointers clear at reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end
endmodule

// One storage device slice of the width-expanded system
module fifo_dev_end #(
   parameter int LANE = 0
) (
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // Link to the host end
   fifo_link_if.dev link
);
   fifo_flags_pkg::dev_state_t st_r; // Registered state
   fifo_flags_pkg::dev_state_t st_nxt; // Next state
   logic wr_strobe; // Write enables active this edge
   logic rd_strobe; // Both read enables active this edge
   logic load_active; // Pin acts as load and is low
   logic do_write; // Word actually stored
   logic do_read; // Word actually read
   logic buf_in_ready; // Buffer has room
   logic buf_out_valid; // Buffer holds a word
   logic [`SLICE_W-1:0] head; // Oldest unread word
   logic [`SLICE_W-1:0] slice_in; // This device's slice of the input

   assign slice_in = link.wr_word[LANE*`SLICE_W +: `SLICE_W];

   // Decode the shared control lines
   always_comb begin
      wr_strobe = !link.write_enable_a_n && link.write_enable_b_or_load;
      rd_strobe = !link.read_enable_a_n && !link.read_enable_b_n;
      load_active = st_r.prog_mode && !link.write_enable_b_or_load;
      // Stores blocked by the registered full flag alone
      do_write = st_r.cfg_done && wr_strobe && st_r.full_n;
      // Reads blocked by the registered empty flag and by an active load pin
      do_read = st_r.cfg_done && rd_strobe && !load_active && st_r.empty_n;
   end

   // Word store shared by both ports
   word_buffer #(
      .WIDTH(`SLICE_W),
      .DEPTH(`DEPTH)
   ) u_store (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .in_valid(do_write),
      .in_ready(buf_in_ready),
      .in_data(slice_in),
      .out_valid(buf_out_valid),
      .out_ready(do_read),
      .out_data(head)
   );

   // Next-state logic for count, flags, output word and offsets
   always_comb begin
      st_nxt = st_r;
      // Capture the pin mode on the first enabled cycle after reset
      if (!st_r.cfg_done) begin
         st_nxt.cfg_done = 1'b1;
         st_nxt.prog_mode = !link.write_enable_b_or_load;
      end
      // Unread-word count from accepted writes and reads
      case ({do_write && buf_in_ready, do_read && buf_out_valid})
         2'b10: st_nxt.count = st_r.count + 1'b1;
         2'b01: st_nxt.count = st_r.count - 1'b1;
         default: st_nxt.count = st_r.count;
      endcase
      // Flags follow the count the store will hold after this edge
      st_nxt.full_n = (st_nxt.count != `CNT_W'(`DEPTH));
      st_nxt.empty_n = (st_nxt.count != '0);
      st_nxt.almost_empty_n = (st_nxt.count > {1'b0, st_r.off_empty});
      st_nxt.almost_full_n = (st_nxt.count < (`CNT_W'(`DEPTH) - {1'b0, st_r.off_full}));
      // Present the head word on a read; otherwise hold the last one
      if (do_read) begin
         st_nxt.q = head;
      end
      // Offset loading and read-back while the load pin is low
      if (st_r.cfg_done && load_active) begin
         if (!link.write_enable_a_n) begin
            // Load the selected offset and step to the other one
            case (st_r.sel)
               fifo_flags_pkg::SEL_EMPTY_OFF: begin
                  st_nxt.off_empty = slice_in[`OFF_W-1:0];
                  st_nxt.sel = fifo_flags_pkg::SEL_FULL_OFF;
               end
               fifo_flags_pkg::SEL_FULL_OFF: begin
                  st_nxt.off_full = slice_in[`OFF_W-1:0];
                  st_nxt.sel = fifo_flags_pkg::SEL_EMPTY_OFF;
               end
               default: st_nxt.sel = fifo_flags_pkg::SEL_EMPTY_OFF;
            endcase
         end else if (rd_strobe) begin
            // Read the selected offset onto the data outputs
            case (st_r.sel)
               fifo_flags_pkg::SEL_EMPTY_OFF: begin
                  st_nxt.q = {{(`SLICE_W-`OFF_W){1'b0}}, st_r.off_empty};
                  st_nxt.sel = fifo_flags_pkg::SEL_FULL_OFF;
               end
               fifo_flags_pkg::SEL_FULL_OFF: begin
                  st_nxt.q = {{(`SLICE_W-`OFF_W){1'b0}}, st_r.off_full};
                  st_nxt.sel = fifo_flags_pkg::SEL_EMPTY_OFF;
               end
               default: st_nxt.sel = fifo_flags_pkg::SEL_EMPTY_OFF;
            endcase
         end
      end
   end

   // State register; reset lands in the empty state with default offsets
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.full_n <= 1'b1;
         st_r.empty_n <= 1'b0;
         st_r.almost_empty_n <= 1'b0;
         st_r.almost_full_n <= 1'b1;
         st_r.sel <= fifo_flags_pkg::SEL_EMPTY_OFF;
         st_r.off_empty <= `OFF_DEFAULT;
         st_r.off_full <= `OFF_DEFAULT;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // Drive this slice's outputs straight from the state register
   assign link.rd_word[LANE*`SLICE_W +: `SLICE_W] = st_r.q;
   assign link.full_flag_n[LANE] = st_r.full_n;
   assign link.empty_flag_n[LANE] = st_r.empty_n;
   assign link.almost_empty_flag_n[LANE] = st_r.almost_empty_n;
   assign link.almost_full_flag_n[LANE] = st_r.almost_full_n;
endmodule

`default_nettype wire

// [fifo_flags_defs.svh]
`ifndef FIFO_FLAGS_DEFS_SVH
`define FIFO_FLAGS_DEFS_SVH

// Width of one device slice of the data word
`define SLICE_W 9
// Number of device slices joined side by side
`define LANES 2
// Full word width across all slices
`define WORD_W 18
// Storage depth of each device in words
`define DEPTH 32
// Width of the unread-word count
`define CNT_W 6
// Width of a read or write pointer
`define PTR_W 5
// Width of an almost-flag offset
`define OFF_W 5
// Offset loaded into both almost thresholds at reset
`define OFF_DEFAULT 5'h07

`endif

// [fifo_flags_pkg.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

package fifo_flags_pkg;

   // Offset register selected by the next load or offset read
   typedef enum logic {
      SEL_EMPTY_OFF,
      SEL_FULL_OFF
   } off_sel_t;

   // State of the device end, apart from the word store held in word_buffer
   typedef struct packed {
      logic [`CNT_W-1:0] count;
      logic full_n;
      logic empty_n;
      logic almost_empty_n;
      logic almost_full_n;
      logic [`SLICE_W-1:0] q;
      logic cfg_done;
      logic prog_mode;
      off_sel_t sel;
      logic [`OFF_W-1:0] off_empty;
      logic [`OFF_W-1:0] off_full;
   } dev_state_t;

   // Complete state of the host end
   typedef struct packed {
      logic wen_a_n;
      logic wen_b;
      logic ren_a_n;
      logic [`WORD_W-1:0] wdata;
      logic pend;
      logic wr_ready;
      logic rd_issued;
      logic [`WORD_W-1:0] rdata;
      logic rd_valid;
      logic full_n;
      logic empty_n;
      logic almost_empty_n;
      logic almost_full_n;
   } host_state_t;

endpackage

`default_nettype wire

// [fifo_host_end.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

// Writer and reader for a width-expanded pair of storage devices
module fifo_host_end (
   // Clock, reset and enable
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   // User write side
   input wire logic wr_valid,
   input wire logic [`WORD_W-1:0] wr_data,
   output logic wr_ready,
   // User read side
   input wire logic rd_enable,
   output logic rd_valid,
   output logic [`WORD_W-1:0] rd_data,
   // Status for the user: full and empty merged, almost flags from slice 0
   output logic full_n,
   output logic empty_n,
   output logic almost_empty_n,
   output logic almost_full_n,
   // Link to all device slices
   fifo_link_if.host link
);
   fifo_flags_pkg::host_state_t st_r; // Registered state
   fifo_flags_pkg::host_state_t st_nxt; // Next state
   logic all_full_n; // Composite full flag
   logic all_empty_n; // Composite empty flag
   logic wr_taken; // Presented word stored this edge
   logic rd_taken; // Read performed this edge
   logic take_user; // New word accepted from the user

   // Composite end-point flags: any low slice makes the whole low
   assign all_full_n = &link.full_flag_n;
   assign all_empty_n = &link.empty_flag_n;

   // Transfers the devices perform at this edge
   always_comb begin
      wr_taken = !st_r.wen_a_n && st_r.wen_b && all_full_n;
      rd_taken = !st_r.ren_a_n && all_empty_n;
      take_user = wr_valid && st_r.wr_ready;
   end

   // Next-state logic for the write and read sides
   always_comb begin
      st_nxt = st_r;
      // Load pin leaves its reset-time low level after release
      st_nxt.wen_b = 1'b1;
      // Write side: one word held until stored
      st_nxt.pend = (st_r.pend && !wr_taken) || take_user;
      if (take_user) begin
         st_nxt.wdata = wr_data;
      end
      st_nxt.wen_a_n = !st_nxt.pend;
      st_nxt.wr_ready = !st_nxt.pend;
      // Read side: request only while the merged empty flag is high
      st_nxt.ren_a_n = !(rd_enable && all_empty_n && !rd_taken);
      st_nxt.rd_issued = rd_taken;
      st_nxt.rd_valid = st_r.rd_issued;
      if (st_r.rd_issued) begin
         st_nxt.rdata = link.rd_word;
      end
      // Status for the user, one cycle behind the link: full and empty merged, almost flags from slice 0 only
      st_nxt.full_n = all_full_n;
      st_nxt.empty_n = all_empty_n;
      st_nxt.almost_empty_n = link.almost_empty_flag_n[0];
      st_nxt.almost_full_n = link.almost_full_flag_n[0];
   end

   // State register; enables idle and load pin low during reset
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_r <= '0;
         st_r.wen_a_n <= 1'b1;
         st_r.wen_b <= 1'b0;
         st_r.ren_a_n <= 1'b1;
         st_r.wr_ready <= 1'b0;
         // Status idles as an empty store: not full, empty, almost empty
         st_r.full_n <= 1'b1;
         st_r.almost_full_n <= 1'b1;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end

   // One source drives the controls of every slice
   assign link.write_enable_a_n = st_r.wen_a_n;
   assign link.write_enable_b_or_load = st_r.wen_b;
   assign link.read_enable_a_n = st_r.ren_a_n;
   assign link.read_enable_b_n = 1'b0;
   assign link.wr_word = st_r.wdata;
   assign wr_ready = st_r.wr_ready;
   assign rd_valid = st_r.rd_valid;
   assign rd_data = st_r.rdata;
   assign full_n = st_r.full_n;
   assign empty_n = st_r.empty_n;
   assign almost_empty_n = st_r.almost_empty_n;
   assign almost_full_n = st_r.almost_full_n;
endmodule

`default_nettype wire

// [fifo_link_if.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

interface fifo_link_if;
   // Shared control lines, one source for all slices
   logic write_enable_a_n;
   logic write_enable_b_or_load;
   logic read_enable_a_n;
   logic read_enable_b_n;
   // Data, one slice per device
   logic [`WORD_W-1:0] wr_word;
   // Nets, since each slice drives only its own part of these
   wire logic [`WORD_W-1:0] rd_word;
   // Per-device status flags
   wire logic [`LANES-1:0] full_flag_n;
   wire logic [`LANES-1:0] empty_flag_n;
   wire logic [`LANES-1:0] almost_empty_flag_n;
   wire logic [`LANES-1:0] almost_full_flag_n;

   // Storage device end
   modport dev (
      input write_enable_a_n, write_enable_b_or_load, read_enable_a_n, read_enable_b_n,
      input wr_word,
      output rd_word, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n
   );

   // Writer and reader end
   modport host (
      output write_enable_a_n, write_enable_b_or_load, read_enable_a_n, read_enable_b_n,
      output wr_word,
      input rd_word, full_flag_n, empty_flag_n, almost_empty_flag_n, almost_full_flag_n
   );
endinterface

`default_nettype wire

// [fifo_link_props.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

// Watches the link that joins the host end to both device slices
module fifo_link_props (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // Shared control lines
   input wire logic write_enable_a_n,
   input wire logic write_enable_b_or_load,
   input wire logic read_enable_a_n,
   input wire logic read_enable_b_n,
   // Read data
   input wire logic [`WORD_W-1:0] rd_word,
   // Per-slice flags
   input wire logic [`LANES-1:0] full_flag_n,
   input wire logic [`LANES-1:0] empty_flag_n,
   input wire logic [`LANES-1:0] almost_empty_flag_n,
   input wire logic [`LANES-1:0] almost_full_flag_n
);
   // All checks sample on the rising edge, off during reset
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstn);

   // Both write enables active
   logic wr_on;
   assign wr_on = !write_enable_a_n && write_enable_b_or_load;

   reset_state_a: assert property ($rose(rstn) |-> empty_flag_n == 2'b00 &&
      full_flag_n == 2'b11 && almost_empty_flag_n == 2'b00 && almost_full_flag_n == 2'b11)
      else $error("flags wrong after reset");
   load_low_a: assert property ($rose(rstn) |-> !$past(write_enable_b_or_load))
      else $error("load pin high during reset");
   ren_b_tied_a: assert property (read_enable_b_n == 1'b0)
      else $error("second read enable not low");
   lanes_agree_a: assert property (full_flag_n[0] == full_flag_n[1] &&
      empty_flag_n[0] == empty_flag_n[1] && almost_empty_flag_n[0] == almost_empty_flag_n[1])
      else $error("slice flags disagree");
   full_hold_a: assert property (!full_flag_n[0] && read_enable_a_n |=>
      full_flag_n == 2'b00) else $error("full flag left without a read");
   full_on_read_a: assert property (!full_flag_n[0] && !read_enable_a_n |=>
      full_flag_n == 2'b11) else $error("full flag kept after a read");
   empty_hold_a: assert property (!empty_flag_n[0] && !wr_on |=>
      empty_flag_n == 2'b00) else $error("empty flag left without a write");
   empty_on_write_a: assert property (!empty_flag_n[0] && wr_on |=>
      empty_flag_n == 2'b11) else $error("empty flag kept after a write");
   rd_hold_a: assert property (!empty_flag_n[0] |=> $stable(rd_word))
      else $error("read data moved while empty");
endmodule

`default_nettype wire

// [tb.sv]
`default_nettype none
`include "fifo_flags_defs.svh"

// Drives the host user side and checks data and merged flags
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Clock, reset and run enable
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   // User side stimulus
   logic wr_valid = 1'b0;
   logic [`WORD_W-1:0] wr_data = '0;
   logic rd_enable = 1'b0;
   // User side results
   logic wr_ready, rd_valid, full_n, empty_n, almost_empty_n, almost_full_n;
   logic [`WORD_W-1:0] rd_data;
   // Tallies
   int error_cnt = 0;
   int n_checks = 0;

   fifo_link_if link ();
   fifo_host_end fifo_host_end_i (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready), .rd_enable(rd_enable),
      .rd_valid(rd_valid), .rd_data(rd_data), .full_n(full_n), .empty_n(empty_n),
      .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n), .link(link));
   fifo_dev_end #(.LANE(0)) fifo_dev_end_i0 (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .link(link));
   fifo_dev_end #(.LANE(1)) fifo_dev_end_i1 (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .link(link));
   fifo_link_props fifo_link_props_i (.sys_clk(sys_clk), .rstn(rstn),
      .write_enable_a_n(link.write_enable_a_n),
      .write_enable_b_or_load(link.write_enable_b_or_load),
      .read_enable_a_n(link.read_enable_a_n), .read_enable_b_n(link.read_enable_b_n),
      .rd_word(link.rd_word), .full_flag_n(link.full_flag_n),
      .empty_flag_n(link.empty_flag_n), .almost_empty_flag_n(link.almost_empty_flag_n),
      .almost_full_flag_n(link.almost_full_flag_n));

   // 25 MHz clock
   always #20 sys_clk = ~sys_clk;

   // Distinct word with different slices
   function automatic logic [`WORD_W-1:0] word(input int i);
      return 18'(18'h0a5a5 + i * 18'h00731);
   endfunction

   // Compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Let some clock edges pass
   task automatic idle(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // Merged full and empty flags and slice 0 almost flags for a given number of unread words
   task automatic flags(input int k);
      idle(4);
      check(full_n, k < `DEPTH);
      check(empty_n, k > 0);
      check(almost_empty_n, k > 7);
      check(almost_full_n, k < `DEPTH - 7);
   endtask

   // Offer one word once the host is ready
   task automatic push(input logic [`WORD_W-1:0] d);
      int t;
      t = 0;
      @(posedge sys_clk);
      while (wr_ready !== 1'b1 && t < 50) begin
         @(posedge sys_clk);
         t++;
      end
      check(wr_ready, 1'b1);
      wr_valid <= 1'b1;
      wr_data <= d;
      @(posedge sys_clk);
      wr_valid <= 1'b0;
   endtask

   // Request one read and compare the returned word
   task automatic pop(input logic [`WORD_W-1:0] exp);
      int t;
      t = 0;
      @(posedge sys_clk);
      rd_enable <= 1'b1;
      @(posedge sys_clk);
      rd_enable <= 1'b0;
      while (rd_valid !== 1'b1 && t < 10) begin
         @(posedge sys_clk);
         t++;
      end
      check(rd_valid, 1'b1);
      check(rd_data, exp);
   endtask

   // Pulse reset low for five cycles
   task automatic do_reset();
      rstn <= 1'b0;
      idle(5);
      rstn <= 1'b1;
      idle(3);
   endtask

   // Print counts and verdict, then stop
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      logic seen;
      idle(5);
      rstn <= 1'b1;
      flags(0);
      check(rd_data, 18'h00000);
      $display("Test reset done");
      // Fill to the last location, flags follow each word
      for (int k = 1; k <= `DEPTH; k++) begin
         push(word(k));
         flags(k);
      end
      // A further offer is held by the host and refused by the slices while full
      wr_valid <= 1'b1;
      wr_data <= word(99);
      idle(20);
      check(wr_ready, 1'b0);
      check(full_n, 1'b0);
      wr_valid <= 1'b0;
      $display("Test fill done");
      // The held word lands only once the first read makes room
      pop(word(1));
      flags(`DEPTH);
      // Drain in order, flags follow each read
      for (int j = 2; j <= `DEPTH; j++) begin
         pop(word(j));
         flags(`DEPTH + 1 - j);
      end
      pop(word(99));
      flags(0);
      // A read while empty returns nothing and keeps the output
      seen = 1'b0;
      @(posedge sys_clk);
      rd_enable <= 1'b1;
      @(posedge sys_clk);
      rd_enable <= 1'b0;
      repeat (6) begin
         @(posedge sys_clk);
         if (rd_valid === 1'b1) seen = 1'b1;
      end
      check(seen, 1'b0);
      check(rd_data, word(99));
      $display("Test drain done");
      // Reset in mid-run discards stored words
      for (int k = 1; k <= 3; k++) push(word(k + 40));
      idle(3);
      do_reset();
      flags(0);
      push(word(50));
      flags(1);
      pop(word(50));
      $display("Test mid reset done");
      // Clock enable low freezes both ends, so an offer is not taken
      ce <= 1'b0;
      wr_valid <= 1'b1;
      wr_data <= word(60);
      idle(6);
      check(wr_ready, 1'b1);
      check(empty_n, 1'b0);
      ce <= 1'b1;
      wr_valid <= 1'b0;
      flags(0);
      $display("Test clock enable done");
      final_report();
   end

   // Cut a hang short
   initial begin
      #(40 * 30000);
      error_cnt++;
      final_report();
   end
endmodule

`default_nettype wire
